/* File: hdl/owcd_decode.v */
// Oscillator and watchdog configuration word decoder.
// Assumes config words are stable nonvolatile bits synchronous to mclk_i.
// Functional notes
// - Bits 7-6 control clock switching and monitor
// - Bits 4-3 select primary oscillator band
// - Bit 7 forces watchdog, else software
// - Bit 6 one selects non-windowed watchdog
// - Bit 4 picks one of two prescalers
// - Postscale ratio doubles per code step
// - Postscale ratio is two to code
// - Unprogrammed bits read one, programmed zero; watchdog bit 5 always reads zero
`timescale 1ns/1ps
`default_nettype none
`include "owcd_map.vh"
module owcd_decode #(
	parameter RATIO_W = 16
)
(
	// Clock and reset
	input wire mclk_i,
	input wire nrst_i,
	// Raw configuration words
	input wire [7:0] osc_cfg_i,
	input wire [7:0] wdt_cfg_i,
	// Software watchdog enable
	input wire watchdog_soft_enable_i,
	// Read-back of the words
	output reg [7:0] osc_cfg_rd_o,
	output reg [7:0] wdt_cfg_rd_o,
	// Oscillator settings
	output reg clock_switch_en_o,
	output reg fail_safe_monitor_en_o,
	output reg [1:0] primary_osc_range_o,
	output reg range_high_o,
	output reg range_mid_o,
	output reg range_low_o,
	output reg secondary_osc_power_sel_o,
	output reg clock_out_pin_function_o,
	output reg [1:0] primary_osc_mode_o,
	// Watchdog settings
	output reg watchdog_enable_o,
	output reg watchdog_fuse_enable_o,
	output reg window_mode_en_o,
	output reg watchdog_prescale_sel_o,
	output reg [3:0] watchdog_postscale_sel_o,
	output reg [RATIO_W-1:0] postscale_ratio_o
);
	// Held configuration words
	reg [7:0] osc_reg;
	reg [7:0] wdt_reg;
	reg [7:0] osc_next;
	reg [7:0] wdt_next;

	// Field views of the held words
	wire [1:0] csm;
	wire [1:0] rng;
	wire [3:0] post_code;
	wire [RATIO_W-1:0] ratio;

	// Next values of the oscillator outputs
	reg [7:0] osc_rd_next;
	reg clock_switch_en_next;
	reg fail_safe_monitor_en_next;
	reg [1:0] primary_osc_range_next;
	reg range_high_next;
	reg range_mid_next;
	reg range_low_next;
	reg secondary_osc_power_sel_next;
	reg clock_out_pin_function_next;
	reg [1:0] primary_osc_mode_next;

	// Next values of the watchdog outputs
	reg [7:0] wdt_rd_next;
	reg watchdog_enable_next;
	reg watchdog_fuse_enable_next;
	reg window_mode_en_next;
	reg watchdog_prescale_sel_next;
	reg [3:0] watchdog_postscale_sel_next;
	reg [RATIO_W-1:0] postscale_ratio_next;

	// Words follow the inputs only while in reset
	always @*
	begin
		osc_next = osc_reg;
		wdt_next = wdt_reg;
		if (!nrst_i)
		begin
			osc_next = osc_cfg_i;
			wdt_next = wdt_cfg_i & `OWCD_WDT_ERASED;
		end
	end

	// Held words; last reset edge wins
	always @(posedge mclk_i)
	begin
		osc_reg <= osc_next;
		wdt_reg <= wdt_next;
	end

	assign csm = osc_reg[`OWCD_CSM_HI:`OWCD_CSM_LO];
	assign rng = osc_reg[`OWCD_RANGE_HI:`OWCD_RANGE_LO];
	assign post_code = wdt_reg[`OWCD_POST_HI:`OWCD_POST_LO];

	owcd_postscale #(
		.CODE_W(4),
		.RATIO_W(RATIO_W)
	) u_post (
		.code_i(post_code),
		.ratio_o(ratio)
	);

	// Oscillator decode; reset shows the unprogrammed setting
	always @*
	begin
		osc_rd_next = `OWCD_OSC_ERASED;
		clock_switch_en_next = 1'b0;
		fail_safe_monitor_en_next = 1'b0;
		primary_osc_range_next = `OWCD_RANGE_HIGH;
		range_high_next = 1'b1;
		range_mid_next = 1'b0;
		range_low_next = 1'b0;
		secondary_osc_power_sel_next = 1'b1;
		clock_out_pin_function_next = 1'b1;
		primary_osc_mode_next = `OWCD_PMODE_ERASED;
		if (nrst_i)
		begin
			osc_rd_next = osc_reg;
			primary_osc_range_next = rng;
			range_high_next = 1'b0;
			secondary_osc_power_sel_next = osc_reg[`OWCD_SOSC_BIT];
			clock_out_pin_function_next = osc_reg[`OWCD_CLKOUT_BIT];
			primary_osc_mode_next = osc_reg[`OWCD_PMODE_HI:`OWCD_PMODE_LO];
			case (csm)
				`OWCD_CSM_SW_ON:
				begin
					clock_switch_en_next = 1'b1;
				end
				`OWCD_CSM_ALL_ON:
				begin
					clock_switch_en_next = 1'b1;
					fail_safe_monitor_en_next = 1'b1;
				end
				default:
				begin
					clock_switch_en_next = 1'b0;
				end
			endcase
			case (rng)
				`OWCD_RANGE_HIGH:
				begin
					range_high_next = 1'b1;
				end
				`OWCD_RANGE_MID:
				begin
					range_mid_next = 1'b1;
				end
				`OWCD_RANGE_LOW:
				begin
					range_low_next = 1'b1;
				end
				default:
				begin
					range_high_next = 1'b0;
				end
			endcase
		end
	end

	// Watchdog decode; reset shows the unprogrammed setting
	always @*
	begin
		wdt_rd_next = `OWCD_WDT_ERASED;
		watchdog_fuse_enable_next = 1'b1;
		watchdog_enable_next = 1'b1;
		window_mode_en_next = 1'b0;
		watchdog_prescale_sel_next = 1'b1;
		watchdog_postscale_sel_next = `OWCD_POST_ERASED;
		postscale_ratio_next = {1'b1, {(RATIO_W-1){1'b0}}};
		if (nrst_i)
		begin
			wdt_rd_next = wdt_reg;
			watchdog_fuse_enable_next = wdt_reg[`OWCD_WDT_EN_BIT];
			watchdog_enable_next = wdt_reg[`OWCD_WDT_EN_BIT] | watchdog_soft_enable_i;
			window_mode_en_next = ~wdt_reg[`OWCD_WIN_DIS_BIT];
			watchdog_prescale_sel_next = wdt_reg[`OWCD_PRESC_BIT];
			watchdog_postscale_sel_next = post_code;
			postscale_ratio_next = ratio;
		end
	end

	// Oscillator outputs straight from flops
	always @(posedge mclk_i)
	begin
		osc_cfg_rd_o <= osc_rd_next;
		clock_switch_en_o <= clock_switch_en_next;
		fail_safe_monitor_en_o <= fail_safe_monitor_en_next;
		primary_osc_range_o <= primary_osc_range_next;
		range_high_o <= range_high_next;
		range_mid_o <= range_mid_next;
		range_low_o <= range_low_next;
		secondary_osc_power_sel_o <= secondary_osc_power_sel_next;
		clock_out_pin_function_o <= clock_out_pin_function_next;
		primary_osc_mode_o <= primary_osc_mode_next;
	end

	// Watchdog outputs straight from flops
	always @(posedge mclk_i)
	begin
		wdt_cfg_rd_o <= wdt_rd_next;
		watchdog_enable_o <= watchdog_enable_next;
		watchdog_fuse_enable_o <= watchdog_fuse_enable_next;
		window_mode_en_o <= window_mode_en_next;
		watchdog_prescale_sel_o <= watchdog_prescale_sel_next;
		watchdog_postscale_sel_o <= watchdog_postscale_sel_next;
		postscale_ratio_o <= postscale_ratio_next;
	end
endmodule // owcd_decode
`default_nettype wire

/* File: hdl/owcd_map.vh */
// Field positions, widths and unprogrammed values of the two configuration words.
// Assumes inclusion by the decoder files of this block only.
`ifndef OWCD_MAP_VH
`define OWCD_MAP_VH

// Oscillator word fields
`define OWCD_CSM_HI 7
`define OWCD_CSM_LO 6
`define OWCD_SOSC_BIT 5
`define OWCD_RANGE_HI 4
`define OWCD_RANGE_LO 3
`define OWCD_CLKOUT_BIT 2
`define OWCD_PMODE_HI 1
`define OWCD_PMODE_LO 0

// Watchdog word fields
`define OWCD_WDT_EN_BIT 7
`define OWCD_WIN_DIS_BIT 6
`define OWCD_WDT_RSVD_BIT 5
`define OWCD_PRESC_BIT 4
`define OWCD_POST_HI 3
`define OWCD_POST_LO 0

// Clock switch codes
`define OWCD_CSM_SW_ON 2'h1
`define OWCD_CSM_ALL_ON 2'h0

// Range codes
`define OWCD_RANGE_HIGH 2'h3
`define OWCD_RANGE_MID 2'h2
`define OWCD_RANGE_LOW 2'h1

// Unprogrammed word and field values
`define OWCD_OSC_ERASED 8'hff
`define OWCD_WDT_ERASED 8'hdf
`define OWCD_PMODE_ERASED 2'h3
`define OWCD_POST_ERASED 4'hf

`endif

/* File: hdl/owcd_postscale.v */
// Postscale code to ratio decoder.
// Assumes a four-bit code; ratio is a one-hot power of two.
`timescale 1ns/1ps
`default_nettype none
module owcd_postscale #(
	parameter CODE_W = 4,
	parameter RATIO_W = 16
)
(
	// Code in
	input wire [CODE_W-1:0] code_i,
	// Ratio out
	output wire [RATIO_W-1:0] ratio_o
);
	assign ratio_o = {{(RATIO_W-1){1'b0}}, 1'b1} << code_i;
endmodule // owcd_postscale
`default_nettype wire

/* File: tb/owcd_asserts.sv */
// Decoder output checker.
// Bound into owcd_decode.
`timescale 1ns/1ps
`default_nettype none
module owcd_asserts #(parameter RATIO_W = 16) (
	input wire logic mclk_i, nrst_i, clock_switch_en_o, fail_safe_monitor_en_o,
	input wire logic range_high_o, watchdog_enable_o, window_mode_en_o,
	input wire logic watchdog_soft_enable_i,
	input wire logic [7:0] osc_cfg_rd_o, wdt_cfg_rd_o,
	input wire logic [RATIO_W-1:0] postscale_ratio_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_run; nrst_i [*4]; endsequence
	a_sw_off:
	assert property (clock_switch_en_o != osc_cfg_rd_o[7]) else $error("sw");
	a_mon_on:
	assert property (fail_safe_monitor_en_o == !osc_cfg_rd_o[7:6]) else $error("fs");
	a_range_high:
	assert property (range_high_o == &osc_cfg_rd_o[4:3]) else $error("rg");
	a_fuse_force:
	assert property (wdt_cfg_rd_o[7] |-> watchdog_enable_o) else $error("we");
	a_soft_only:
	assert property (!wdt_cfg_rd_o[7] |-> watchdog_enable_o == $past(watchdog_soft_enable_i))
		else $error("ws");
	a_window_sel:
	assert property (window_mode_en_o != wdt_cfg_rd_o[6]) else $error("wi");
	a_ratio_pow:
	assert property (postscale_ratio_o == 1 << wdt_cfg_rd_o[3:0]) else $error("ra");
	a_unprog_ones:
	assert property (!$past(nrst_i) |-> {osc_cfg_rd_o, wdt_cfg_rd_o} == 16'hffdf) else $error("df");
	a_hold_words:
	assert property (s_run |-> $stable({osc_cfg_rd_o, wdt_cfg_rd_o})) else $error("hd");
endmodule // owcd_asserts
bind owcd_decode owcd_asserts #(.RATIO_W(RATIO_W)) u_chk (.*);
`default_nettype wire

/* File: tb/osc_wdt_config_decode_bench.sv */
// Decoder bench, random and corner words.
// Assumes owcd_decode on a 5 ns clock.
`timescale 1ns/1ps
`default_nettype none
module osc_wdt_config_decode_bench;
	logic mclk_i = 0, nrst_i = 0, sw = 0;
	logic [7:0] o = 8'hff, w = 8'hff, ord, wrd;
	wire [7:0] d;
	wire [10:0] f;
	logic [15:0] r;
	logic [31:0] s = 32'h112ee;
	int bad_count = 0, total_checks = 0;
	owcd_decode DUT (.mclk_i, .nrst_i, .osc_cfg_i(o), .wdt_cfg_i(w), .watchdog_soft_enable_i(sw),
		.osc_cfg_rd_o(ord), .wdt_cfg_rd_o(wrd), .clock_switch_en_o(d[7]),
		.fail_safe_monitor_en_o(d[6]), .primary_osc_range_o(f[10:9]), .range_high_o(d[5]),
		.range_mid_o(d[4]), .range_low_o(d[3]), .secondary_osc_power_sel_o(f[8]),
		.clock_out_pin_function_o(f[7]), .primary_osc_mode_o(f[6:5]), .watchdog_enable_o(d[2]),
		.watchdog_fuse_enable_o(f[4]), .window_mode_en_o(d[1]), .watchdog_prescale_sel_o(d[0]),
		.watchdog_postscale_sel_o(f[3:0]), .postscale_ratio_o(r));
	initial forever #2.5 mclk_i = ~mclk_i;
	// Expected read-back, decode and ratio
	function automatic [50:0] ex(input [7:0] a, b, input e);
		return {a, b & 8'hdf, ~a[7], a[7:6] == 2'h0, a[4:3] == 2'h3, a[4:3] == 2'h2,
			a[4:3] == 2'h1, b[7] | e, ~b[6], b[4], 16'h1 << b[3:0],
			a[4:3], a[5], a[2], a[1:0], b[7], b[3:0]};
	endfunction
	// Xorshift step for the random words
	function automatic [31:0] xs(input [31:0] v);
		reg [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic boot(input [7:0] a, b);
		@(posedge mclk_i) #1 {nrst_i, o, w, sw} = {1'b0, a, b, 1'b0};
		@(posedge mclk_i) #1 {nrst_i, o, w} = {1'b1, ~a, ~b};
		for (int e = 0; e < 2; e++)
		begin
			repeat (2) @(posedge mclk_i);
			#1 total_checks++;
			if ({ord, wrd, d, r, f} !== ex(a, b, e[0]))
			begin
				bad_count++;
				$display("BAD outputs exp %h got %h", ex(a, b, e[0]), {ord, wrd, d, r, f});
			end
			sw = 1;
		end
	endtask
	task summarize;
		$display("checks %0d bad %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge mclk_i);
		boot(8'h00, 8'h00);
		boot(8'h40, 8'hff);
		boot(8'h88, 8'h53);
		boot(8'hd0, 8'h6f);
		boot(8'hff, 8'hff);
		repeat (40)
		begin
			s = xs(s);
			boot(s[7:0], s[15:8]);
		end
		summarize;
	end
endmodule // osc_wdt_config_decode_bench
`default_nettype wire
